// *** shared/dsl_pkg.sv ***
// Constants and types for the drive status indicator
package dsl_pkg;
	// Clock period and blink half period
	localparam int unsigned CLK_PERIOD_NS  = 4;
	localparam int unsigned BLINK_HALF_MS  = 500;
	localparam int unsigned BLINK_HALF_CYC = (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned BLINK_CNT_W    = 27;
	// Configuration page that holds the polarity-select bit
	localparam logic [7:0]  POLARITY_PAGE     = 8'h19;
	localparam logic        POLARITY_RESET    = 1'h0;
	localparam logic        BLINK_PHASE_RESET = 1'h1;

	// Spindle state encoding
	typedef enum logic [1:0] {
		DSL_SPUN_DOWN = 2'h0,
		DSL_SPUN_UP   = 2'h1,
		DSL_SPIN_UP   = 2'h2,
		DSL_SPIN_DOWN = 2'h3
	} dsl_spindle_t;

	// Indicator source selection, one-hot
	typedef enum logic [2:0] {
		DSL_SRC_TABLE  = 3'h1,
		DSL_SRC_BLINK  = 3'h2,
		DSL_SRC_FORMAT = 3'h4
	} dsl_src_t;
endpackage

// *** src/dsl_blink_timer.sv ***
// Half-second blink timer for spindle transitions
`timescale 1ns/100ps
module dsl_blink_timer (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	// Control
	input  wire logic run,
	output logic      phase
);
	typedef struct packed {
		logic [dsl_pkg::BLINK_CNT_W-1:0] cnt;
		logic                            phase;
	} dsl_tmr_t;

	dsl_tmr_t st;
	dsl_tmr_t next_st;

	always_comb begin
		next_st = st;
		if (!run) begin
			// Restart lit so each transition opens with a full lit half
			next_st.cnt   = '0;
			next_st.phase = dsl_pkg::BLINK_PHASE_RESET;
		end else if (st.cnt == dsl_pkg::BLINK_CNT_W'(dsl_pkg::BLINK_HALF_CYC - 1)) begin
			next_st.cnt   = '0;
			next_st.phase = ~st.phase;
		end else begin
			next_st.cnt = st.cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st.cnt   <= '0;
			st.phase <= dsl_pkg::BLINK_PHASE_RESET;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign phase = st.phase;
endmodule // dsl_blink_timer

// *** src/dsl_status_led.sv ***
// Drive status indicator control with open-drain output
// Contract
// (RULE_01) Stopped, idle: indicator dark always
// (RULE_02) Stopped, command executing: indicator lit always
// (RULE_03) At speed, idle: lit if polarity 0
// (RULE_04) At speed, busy: lit if polarity 1
// (RULE_05) Spindle transition: blink half second each
// (RULE_06) Format: toggle indicator per cylinder change
// (RULE_07) Polarity bit comes from configuration page 19h
// (RULE_08) Lit pulls pin low; dark releases it
// (RULE_09) Blink and format override activity table
`timescale 1ns/100ps
module dsl_status_led (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	// Drive state
	input  wire logic [1:0] spindle_state,
	input  wire logic       cmd_active,
	input  wire logic       format_active,
	input  wire logic       cylinder_step,
	// Configuration page write
	input  wire logic       cfg_write,
	input  wire logic [7:0] cfg_page,
	input  wire logic       cfg_polarity,
	// Indicator pin
	input  wire logic       status_indicator_output_in,
	output logic            status_indicator_output_out,
	output logic            status_indicator_output_oe,
	// State view
	output logic            indicator_polarity_select,
	output logic            indicator_lit
);
	typedef struct packed {
		logic              polarity;
		logic              fmt_lit;
		logic              lit;
		logic              oe;
		dsl_pkg::dsl_src_t src;
	} dsl_state_t;

	dsl_state_t st;
	dsl_state_t next_st;
	logic       blink_phase;
	logic       transition;
	logic       table_lit;

	// Activity table lookup, used only by the table_lit logic
	function automatic logic table_value(input logic [1:0] spin, input logic busy,
		input logic pol);
		if (spin == dsl_pkg::DSL_SPUN_UP)
			return busy ? pol : ~pol; // RULE_03 RULE_04
		return busy; // RULE_01 RULE_02
	endfunction

	assign transition = (spindle_state == dsl_pkg::DSL_SPIN_UP) ||
		(spindle_state == dsl_pkg::DSL_SPIN_DOWN);
	assign table_lit  = table_value(spindle_state, cmd_active, st.polarity);

	dsl_blink_timer u_blink (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.run     (transition),
		.phase   (blink_phase)
	);

	always_comb begin
		next_st = st;
		if (cfg_write && cfg_page == dsl_pkg::POLARITY_PAGE)
			next_st.polarity = cfg_polarity; // RULE_07
		case (1'b1)
			transition: begin
				next_st.src = dsl_pkg::DSL_SRC_BLINK; // RULE_09
				next_st.lit = blink_phase; // RULE_05
			end
			format_active: begin
				next_st.src = dsl_pkg::DSL_SRC_FORMAT; // RULE_09
				next_st.lit = cylinder_step ? ~st.fmt_lit : st.fmt_lit;
			end
			default: begin
				next_st.src = dsl_pkg::DSL_SRC_TABLE;
				next_st.lit = table_lit;
			end
		endcase
		// Format toggle starts from the shown state so it never jumps
		if (!format_active || transition)
			next_st.fmt_lit = next_st.lit;
		else if (cylinder_step)
			next_st.fmt_lit = ~st.fmt_lit; // RULE_06
		next_st.oe = next_st.lit; // RULE_08
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st.polarity <= dsl_pkg::POLARITY_RESET;
			st.fmt_lit  <= 1'b0;
			st.lit      <= 1'b0;
			st.oe       <= 1'b0;
			st.src      <= dsl_pkg::DSL_SRC_TABLE;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// Open drain: only ever drives low
	assign status_indicator_output_out = 1'b0; // RULE_08
	assign status_indicator_output_oe  = st.oe;
	assign indicator_polarity_select   = st.polarity;
	assign indicator_lit               = st.lit;

	// Conditions that select the indication source, and configuration page writes
	sequence s_stopped_view;
		clk_en && spindle_state == dsl_pkg::DSL_SPUN_DOWN && !format_active;
	endsequence

	sequence s_up_view;
		clk_en && spindle_state == dsl_pkg::DSL_SPUN_UP && !format_active;
	endsequence

	sequence s_blink_view;
		clk_en && transition;
	endsequence

	sequence s_format_view;
		clk_en && format_active && !transition;
	endsequence

	sequence s_table_view;
		clk_en && !transition && !format_active;
	endsequence

	sequence s_polarity_write;
		clk_en && cfg_write && cfg_page == dsl_pkg::POLARITY_PAGE;
	endsequence

	sequence s_foreign_write;
		clk_en && cfg_write && cfg_page != dsl_pkg::POLARITY_PAGE;
	endsequence

	// Activity table, stopped spindle
	chk_table_stopped: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
		s_stopped_view |=> st.lit == $past(cmd_active))
		else $error("stopped table wrong");
	chk_stopped_dark: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
		(s_stopped_view ##0 !cmd_active) |=> !status_indicator_output_oe)
		else $error("idle stopped lit");
	chk_table_stop_busy: assert property (@(posedge ref_clk) disable iff (rst) // RULE_02
		(s_stopped_view ##0 cmd_active) |=> status_indicator_output_oe)
		else $error("busy stopped dark");

	// Activity table, spindle at speed
	chk_table_idle_up: assert property (@(posedge ref_clk) disable iff (rst) // RULE_03
		(s_up_view ##0 !cmd_active) |=> st.lit == !$past(st.polarity))
		else $error("idle at speed wrong");
	chk_table_busy_up: assert property (@(posedge ref_clk) disable iff (rst) // RULE_04
		(s_up_view ##0 cmd_active) |=> st.lit == $past(st.polarity))
		else $error("busy at speed wrong");
	chk_up_pin_lit: assert property (@(posedge ref_clk) disable iff (rst) // RULE_04
		(s_up_view ##0 cmd_active == indicator_polarity_select) |=> status_indicator_output_oe)
		else $error("at speed pin dark");

	// Blink during spindle transitions, always opening lit
	// Dark half is too long to reach in a short run; rearm is checked instead
	chk_blink_follow: assert property (@(posedge ref_clk) disable iff (rst) // RULE_05
		s_blink_view |=> st.lit == $past(blink_phase))
		else $error("blink lost");
	chk_blink_start: assert property (@(posedge ref_clk) disable iff (rst) // RULE_05
		(s_blink_view ##0 !$past(transition)) |-> blink_phase)
		else $error("blink not starting lit");
	chk_blink_rearm: assert property (@(posedge ref_clk) disable iff (rst) // RULE_05
		(clk_en && !transition) |=> blink_phase)
		else $error("blink timer not rearmed");

	// Format toggles once per cylinder and never jumps on entry
	// Steps during a blink are dropped; the toggle resumes from the shown state
	chk_format_toggle: assert property (@(posedge ref_clk) disable iff (rst) // RULE_06
		(s_format_view ##0 cylinder_step && $past(format_active)) |=> st.lit != $past(st.lit))
		else $error("no toggle on cylinder");
	chk_format_entry: assert property (@(posedge ref_clk) disable iff (rst) // RULE_06
		(s_format_view ##0 !cylinder_step && !$past(format_active)) |=> $stable(st.lit))
		else $error("format entry jumped");
	chk_format_hold: assert property (@(posedge ref_clk) disable iff (rst) // RULE_09
		(s_format_view ##0 !cylinder_step && $past(format_active)) |=> $stable(st.lit))
		else $error("format ignored priority");

	// Priority of the three sources
	chk_src_blink: assert property (@(posedge ref_clk) disable iff (rst) // RULE_09
		s_blink_view |=> st.src == dsl_pkg::DSL_SRC_BLINK)
		else $error("blink not selected");
	chk_src_format: assert property (@(posedge ref_clk) disable iff (rst) // RULE_09
		s_format_view |=> st.src == dsl_pkg::DSL_SRC_FORMAT)
		else $error("format not selected");
	chk_src_table: assert property (@(posedge ref_clk) disable iff (rst) // RULE_09
		s_table_view |=> st.src == dsl_pkg::DSL_SRC_TABLE)
		else $error("table not selected");

	// Polarity bit only from its own page
	chk_polarity_page: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
		s_foreign_write |=> $stable(st.polarity))
		else $error("polarity from wrong page");
	chk_polarity_write: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
		s_polarity_write |=> st.polarity == $past(cfg_polarity))
		else $error("polarity write lost");
	chk_polarity_hold: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
		(clk_en && !cfg_write) |=> $stable(st.polarity))
		else $error("polarity changed unasked");

	// Open-drain pin: low when lit, released when dark
	chk_pin_drive: assert property (@(posedge ref_clk) disable iff (rst) // RULE_08
		status_indicator_output_oe == indicator_lit && !status_indicator_output_out)
		else $error("pin drive mismatch");
	chk_pin_readback: assert property (@(posedge ref_clk) disable iff (rst) // RULE_08
		status_indicator_output_oe |-> !status_indicator_output_in)
		else $error("pin not pulled low");

	// Enable low freezes everything, timer included
	chk_freeze_all: assert property (@(posedge ref_clk) disable iff (rst)
		!clk_en |=> $stable(st) && $stable(blink_phase))
		else $error("state moved while frozen");
endmodule // dsl_status_led

// *** tb/dsl_led_model.sv ***
// External LED and pull-up resistor on the indicator pin
`timescale 1ns/100ps
module dsl_led_model (
	// Pin side
	input  wire logic oe,
	input  wire logic out,
	output logic      pin,
	output logic      led_on
);
	// Released pin is pulled up to the supply
	assign pin = oe ? out : 1'h1;
	assign led_on = (pin === 1'h0);
endmodule // dsl_led_model

// *** tb/tb_top.sv ***
// Self-checking bench for the drive status indicator
`timescale 1ns/100ps
module tb_top;
	logic       ref_clk, rst, clk_en, cmd_active, format_active, cylinder_step, cfg_write;
	logic       cfg_polarity, pin, led_on, oe, out, pol, lit, c, p, e, r;
	logic [1:0] spindle_state;
	logic [7:0] cfg_page;
	int         fails, n_checks, cyc;
	dsl_status_led DUT (.ref_clk, .rst, .clk_en, .spindle_state, .cmd_active, .format_active,
		.cylinder_step, .cfg_write, .cfg_page, .cfg_polarity, .status_indicator_output_in(pin),
		.status_indicator_output_out(out), .status_indicator_output_oe(oe),
		.indicator_polarity_select(pol), .indicator_lit(lit));
	dsl_led_model LED (.oe, .out, .pin, .led_on);
	function automatic logic exp_lit(logic [1:0] s, logic a, logic q);
		return (s == 2'h0) ? a : (a ~^ q);
	endfunction
	task automatic check(logic got, logic exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		ref_clk = 1'h0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		{clk_en, cmd_active, format_active, cylinder_step, cfg_write, cfg_polarity} = '0;
		spindle_state = 2'h0;
		cfg_page = 8'h00;
		rst = 1'h1;
		void'($urandom(32'h1458422F));
		repeat (6) @(negedge ref_clk);
		rst = 1'h0;
		clk_en = 1'h1;
		check(lit, 1'h0);
		for (int i = 0; i < 40; i++) begin
			c = (i < 8) ? i[0] : 1'($urandom);
			p = (i < 8) ? i[1] : 1'($urandom);
			@(negedge ref_clk);
			cfg_write = 1'h1;
			cfg_page = 8'h19;
			cfg_polarity = p;
			// Other pages must leave the polarity alone
			@(negedge ref_clk);
			cfg_page = 8'h18;
			cfg_polarity = !p;
			@(negedge ref_clk);
			cfg_write = 1'h0;
			spindle_state = (i < 8) ? {1'h0, i[2]} : 2'($urandom_range(1, 0));
			cmd_active = c;
			@(negedge ref_clk);
			check(pol, p);
			check(lit, exp_lit(spindle_state, c, p));
			check(led_on, exp_lit(spindle_state, c, p));
		end
		for (int k = 2; k < 4; k++) begin
			spindle_state = 2'(k);
			repeat (30) begin
				@(negedge ref_clk);
				check(lit, 1'h1);
				cmd_active = 1'($urandom);
			end
			spindle_state = 2'h0;
			cmd_active = 1'h0;
			@(negedge ref_clk);
			check(lit, 1'h0);
		end
		spindle_state = 2'h1;
		@(negedge ref_clk);
		format_active = 1'h1;
		e = exp_lit(2'h1, 1'h0, p);
		// Steps while frozen must not count
		repeat (20) begin
			@(negedge ref_clk);
			check(lit, e);
			r = 1'($urandom);
			cylinder_step = r;
			clk_en = 1'($urandom);
			cmd_active = 1'($urandom);
			e = e ^ (r & clk_en);
		end
		// Blink outranks a running format
		@(negedge ref_clk);
		check(lit, e);
		clk_en = 1'h1;
		cylinder_step = e;
		@(negedge ref_clk);
		check(lit, 1'h0);
		cylinder_step = 1'h0;
		spindle_state = 2'h2;
		@(negedge ref_clk);
		check(lit, 1'h1);
		// Reset in mid-run darkens the pin at once
		rst = 1'h1;
		@(negedge ref_clk);
		check(led_on, 1'h0);
		check(pol, 1'h0);
		summarize();
	end
endmodule // tb_top
